/* File: hdl/fscl_pkg.sv */
// constants and types of the field compensation and linearizer datapath
package fscl_pkg;
  // register offsets
  localparam logic [4:0] ADDR_STATUS = 5'h01;
  localparam logic [4:0] ADDR_GAIN_TRIM = 5'h03;
  localparam logic [4:0] ADDR_GAIN_TC1 = 5'h04;
  localparam logic [4:0] ADDR_GAIN_TC2 = 5'h05;
  localparam logic [4:0] ADDR_OFFSET_TRIM = 5'h06;
  localparam logic [4:0] ADDR_OFFSET_TC = 5'h07;
  localparam logic [4:0] ADDR_LIN_BASE = 5'h0A;
  localparam logic [4:0] ADDR_LIN_LAST = 5'h12;
  // field positions
  localparam int POL_BIT = 15;
  localparam int COARSE_LSB = 12;
  localparam int FINE_LSB = 0;
  localparam int WARM_LSB = 0;
  localparam int COOL_LSB = 12;
  localparam int QO_LSB = 0;
  localparam int XODD_LSB = 12;
  localparam int LIN_EN_BIT = 12;
  localparam int BIN_BIT = 13;
  localparam int OUT_INV_BIT = 14;
  localparam int IN_INV_BIT = 15;
  // reset values: unity gain, zero offsets, table off
  localparam logic [23:0] GAIN_TRIM_RESET = 24'h000400;
  localparam logic [23:0] REG_RESET = 24'h000000;
  // arithmetic constants
  localparam int REF_TEMP = 25;
  localparam int FINE_BASE = 1024;
  localparam int FINE_Q = 11;
  localparam int GAIN_Q = 16;
  localparam int TC1_SCALE = 1000;
  localparam int TC_NUM_SCALE = 64;
  localparam int TC_DEN = 100000;
  localparam int QOTC_Q = 6;
  localparam int LIN_POINTS = 17;
  localparam int Y_FIRST = -2048;
  localparam int Y_STEP = 256;
  localparam int Y_LOW_LIMIT = -2304;
  localparam int Y_HIGH_LIMIT = 2304;
  localparam int BIN_HIGH = 2048;
  localparam int PIPE_DEPTH = 4;

  typedef struct packed {
    logic signed [15:0] field;
    logic signed [8:0] temp;
  } sample_t;

  typedef struct packed {
    logic signed [12:0] comp;
    logic signed [12:0] lin;
  } result_t;
endpackage

/* File: hdl/field_signal_compensation_linearizer.sv */
// field sample gain/offset compensation and piecewise-linear table
//
// Summary of operation
// - separate warm and cool gain coefficient sets
// - gain = field*pol*coarse*fine*(1+tc terms)
// - gain stage result is signed 17 bits
// - add fixed offset plus drift times deltaT
// - compensation result is signed 13 bits
// - deltaT is ambient minus 25 degrees
// - bit 15 of word 0x3 sets polarity
// - coarse in 14:12, fine in 10:0
// - tc1 at 0x4, tc2 at 0x5 layouts
// - offset at 0x6, drift at 0x7
// - warm at or above 25, else cool
// - 17 programmable 12-bit table x points
// - y points fixed, -2048 step 256
// - equal entries skip outputs, curve jumps
// - lin mode interpolates within a segment
// - below first extrapolate, floor -2304
// - above last extrapolate, cap +2304
// - linearizer result is signed 13 bits
// - bin mode outputs y of entry <= input
// - equal entries give highest entry's y
// - table applied only when enable set
// - bit 14 inverts linearizer output
// - bit 15 inverts linearizer input
// - bin mode: below -2304, above +2048
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module field_signal_compensation_linearizer #(
  parameter int XW = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_addr,
  input wire logic [23:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [23:0] o_rd_data,
  input wire logic i_valid,
  input wire fscl_pkg::sample_t i_sample,
  output logic o_valid,
  output fscl_pkg::result_t o_result
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ****************************************
  // saturation helpers
  // ****************************************
  function automatic logic signed [16:0] sat17(
    input logic signed [63:0] v
  );
    if (v > 64'sd65535) begin
      sat17 = 17'sh0FFFF;
    end else if (v < -64'sd65536) begin
      sat17 = 17'sh10000;
    end else begin
      sat17 = v[16:0];
    end
  endfunction

  function automatic logic signed [12:0] sat13(
    input logic signed [63:0] v
  );
    if (v > 64'sd4095) begin
      sat13 = 13'sh0FFF;
    end else if (v < -64'sd4096) begin
      sat13 = 13'sh1000;
    end else begin
      sat13 = v[12:0];
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [23:0] gain_trim_r;
  logic [23:0] gain_tc1_r;
  logic [23:0] gain_tc2_r;
  logic [23:0] offset_trim_r;
  logic [23:0] offset_tc_r;
  logic [23:0] lin_r [0:8];
  logic [4:0] lin_sel;

  assign lin_sel = i_addr - fscl_pkg::ADDR_LIN_BASE;

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gain_trim_r <= fscl_pkg::GAIN_TRIM_RESET;
      gain_tc1_r <= fscl_pkg::REG_RESET;
      gain_tc2_r <= fscl_pkg::REG_RESET;
      offset_trim_r <= fscl_pkg::REG_RESET;
      offset_tc_r <= fscl_pkg::REG_RESET;
      for (int k = 0; k < 9; k++) begin
        lin_r[k] <= fscl_pkg::REG_RESET;
      end
    end else if (i_wr) begin
      if (i_addr == fscl_pkg::ADDR_GAIN_TRIM) begin
        gain_trim_r <= i_wr_data;
      end else if (i_addr == fscl_pkg::ADDR_GAIN_TC1) begin
        gain_tc1_r <= i_wr_data;
      end else if (i_addr == fscl_pkg::ADDR_GAIN_TC2) begin
        gain_tc2_r <= i_wr_data;
      end else if (i_addr == fscl_pkg::ADDR_OFFSET_TRIM) begin
        offset_trim_r <= i_wr_data;
      end else if (i_addr == fscl_pkg::ADDR_OFFSET_TC) begin
        offset_tc_r <= i_wr_data;
      end else if (i_addr >= fscl_pkg::ADDR_LIN_BASE &&
                   i_addr <= fscl_pkg::ADDR_LIN_LAST) begin
        lin_r[lin_sel[3:0]] <= i_wr_data;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rd_data <= 24'h000000;
    end else if (i_rd) begin
      if (i_addr == fscl_pkg::ADDR_STATUS) begin
        o_rd_data <= {11'h000, o_result.comp};
      end else if (i_addr == fscl_pkg::ADDR_GAIN_TRIM) begin
        o_rd_data <= gain_trim_r;
      end else if (i_addr == fscl_pkg::ADDR_GAIN_TC1) begin
        o_rd_data <= gain_tc1_r;
      end else if (i_addr == fscl_pkg::ADDR_GAIN_TC2) begin
        o_rd_data <= gain_tc2_r;
      end else if (i_addr == fscl_pkg::ADDR_OFFSET_TRIM) begin
        o_rd_data <= offset_trim_r;
      end else if (i_addr == fscl_pkg::ADDR_OFFSET_TC) begin
        o_rd_data <= offset_tc_r;
      end else if (i_addr >= fscl_pkg::ADDR_LIN_BASE &&
                   i_addr <= fscl_pkg::ADDR_LIN_LAST) begin
        o_rd_data <= lin_r[lin_sel[3:0]];
      end else begin
        o_rd_data <= 24'h000000;
      end
    end
  end

  // ****************************************
  // register fields
  // ****************************************
  logic pol;
  logic [2:0] coarse;
  logic [10:0] fine;
  logic signed [10:0] tc1_warm, tc1_cool;
  logic signed [9:0] tc2_warm, tc2_cool;
  logic signed [15:0] fixed_offset_value;
  logic signed [11:0] qotc_warm, qotc_cool;
  logic [23:0] mode_word;

  assign pol = gain_trim_r[fscl_pkg::POL_BIT];
  assign coarse = gain_trim_r[fscl_pkg::COARSE_LSB +: 3];
  assign fine = gain_trim_r[fscl_pkg::FINE_LSB +: 11];
  assign tc1_warm = gain_tc1_r[fscl_pkg::WARM_LSB +: 11];
  assign tc1_cool = gain_tc1_r[fscl_pkg::COOL_LSB +: 11];
  assign tc2_warm = gain_tc2_r[fscl_pkg::WARM_LSB +: 10];
  assign tc2_cool = gain_tc2_r[fscl_pkg::COOL_LSB +: 10];
  assign fixed_offset_value = offset_trim_r[fscl_pkg::QO_LSB +: 16];
  assign qotc_warm = offset_tc_r[fscl_pkg::WARM_LSB +: 12];
  assign qotc_cool = offset_tc_r[fscl_pkg::COOL_LSB +: 12];
  assign mode_word = lin_r[8];

  // ****************************************
  // stage 1: delta-T, region and gain factor
  // ****************************************
  logic signed [9:0] dt;
  logic warm;
  logic signed [63:0] tc_num;
  logic signed [63:0] corr;
  logic s1_valid_r;
  logic signed [15:0] s1_field_r;
  logic signed [9:0] s1_dt_r;
  logic signed [11:0] s1_qotc_r;
  logic signed [63:0] s1_factor_r;

  assign dt = 10'(i_sample.temp) - 10'(fscl_pkg::REF_TEMP);
  assign warm = (dt >= 10'sd0);

  always_comb begin
    if (warm) begin
      tc_num = 64'(tc2_warm) * 64'(dt) +
               64'(tc1_warm) * 64'(fscl_pkg::TC1_SCALE);
    end else begin
      tc_num = 64'(tc2_cool) * 64'(dt) +
               64'(tc1_cool) * 64'(fscl_pkg::TC1_SCALE);
    end
    corr = (tc_num * 64'(dt) * 64'(fscl_pkg::TC_NUM_SCALE)) /
           64'(fscl_pkg::TC_DEN);
  end

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s1_valid_r <= 1'b0;
      s1_field_r <= 16'sh0000;
      s1_dt_r <= 10'sh000;
      s1_qotc_r <= 12'sh000;
      s1_factor_r <= 64'sh0;
    end else begin
      s1_valid_r <= i_valid;
      s1_field_r <= i_sample.field;
      s1_dt_r <= dt;
      s1_qotc_r <= warm ? qotc_warm : qotc_cool;
      s1_factor_r <= (64'sd1 <<< fscl_pkg::GAIN_Q) + corr;
    end
  end

  // ****************************************
  // stage 2: gain product
  // ****************************************
  logic signed [63:0] gain_prod;
  logic s2_valid_r;
  logic signed [16:0] s2_y1_r;
  logic signed [9:0] s2_dt_r;
  logic signed [11:0] s2_qotc_r;

  always_comb begin
    gain_prod = 64'(s1_field_r) *
                64'(fscl_pkg::FINE_BASE + int'(fine)) * s1_factor_r;
    gain_prod = (gain_prod <<< coarse) >>>
                (fscl_pkg::FINE_Q + fscl_pkg::GAIN_Q);
    if (pol) begin
      gain_prod = -gain_prod;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s2_valid_r <= 1'b0;
      s2_y1_r <= 17'sh00000;
      s2_dt_r <= 10'sh000;
      s2_qotc_r <= 12'sh000;
    end else begin
      s2_valid_r <= s1_valid_r;
      s2_y1_r <= sat17(gain_prod);
      s2_dt_r <= s1_dt_r;
      s2_qotc_r <= s1_qotc_r;
    end
  end

  // ****************************************
  // stage 3: offset
  // ****************************************
  logic signed [63:0] offs_sum;
  logic s3_valid_r;
  logic signed [12:0] s3_y2_r;

  always_comb begin
    offs_sum = 64'(s2_y1_r) + 64'(fixed_offset_value) +
               ((64'(s2_qotc_r) * 64'(s2_dt_r)) >>>
                fscl_pkg::QOTC_Q);
  end

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s3_valid_r <= 1'b0;
      s3_y2_r <= 13'sh0000;
    end else begin
      s3_valid_r <= s2_valid_r;
      s3_y2_r <= sat13(offs_sum);
    end
  end

  // ****************************************
  // stage 4: linearizer
  // ****************************************
  logic signed [12:0] xt [0:16];
  logic [16:0] at_or_above;
  logic signed [12:0] lin_in;
  logic [4:0] cnt;
  logic signed [63:0] ylin;
  logic signed [63:0] xa, xb, ybase;

  assign lin_in = mode_word[fscl_pkg::IN_INV_BIT] ?
                  sat13(-64'(s3_y2_r)) : s3_y2_r;

  // even points in low half, odd points in high half of words 0 to 7; word 8 holds point 16 in its low half
  genvar g;
  generate
    for (g = 0; g < fscl_pkg::LIN_POINTS; g++) begin : g_pt
      if (g % 2 == 0) begin : g_even
        assign xt[g] = 13'(signed'(lin_r[g / 2][XW - 1:0]));
      end else begin : g_odd
        assign xt[g] = 13'(signed'(
          lin_r[g / 2][fscl_pkg::XODD_LSB +: XW]));
      end
      assign at_or_above[g] = (lin_in >= xt[g]);
    end
  endgenerate

  always_comb begin
    cnt = 5'd0;
    for (int k = 0; k < fscl_pkg::LIN_POINTS; k++) begin
      cnt = cnt + {4'd0, at_or_above[k]};
    end
    xa = 64'sd0;
    xb = 64'sd0;
    ybase = 64'(fscl_pkg::Y_FIRST) +
            64'(fscl_pkg::Y_STEP) * 64'(cnt) -
            64'(fscl_pkg::Y_STEP);
    if (mode_word[fscl_pkg::BIN_BIT]) begin
      if (cnt == 5'd0) begin
        ylin = 64'(fscl_pkg::Y_LOW_LIMIT);
      end else if (cnt == 5'd17) begin
        ylin = 64'(fscl_pkg::BIN_HIGH);
      end else begin
        ylin = ybase;
      end
    end else if (cnt == 5'd0) begin
      xa = 64'(xt[0]);
      xb = 64'(xt[1]);
      if (xb == xa) begin
        ylin = 64'(fscl_pkg::Y_LOW_LIMIT);
      end else begin
        ylin = 64'(fscl_pkg::Y_FIRST) -
               ((xa - 64'(lin_in)) * 64'(fscl_pkg::Y_STEP)) /
               (xb - xa);
      end
      if (ylin < 64'(fscl_pkg::Y_LOW_LIMIT)) begin
        ylin = 64'(fscl_pkg::Y_LOW_LIMIT);
      end
    end else if (cnt == 5'd17) begin
      xa = 64'(xt[15]);
      xb = 64'(xt[16]);
      if (xb == xa) begin
        ylin = 64'(fscl_pkg::Y_HIGH_LIMIT);
      end else begin
        ylin = 64'(fscl_pkg::BIN_HIGH) +
               ((64'(lin_in) - xb) * 64'(fscl_pkg::Y_STEP)) /
               (xb - xa);
      end
      if (ylin > 64'(fscl_pkg::Y_HIGH_LIMIT)) begin
        ylin = 64'(fscl_pkg::Y_HIGH_LIMIT);
      end
    end else begin
      // next point lies strictly above input, so no zero span
      xa = 64'(xt[cnt - 5'd1]);
      xb = 64'(xt[cnt]);
      ylin = ybase + ((64'(lin_in) - xa) *
             64'(fscl_pkg::Y_STEP)) / (xb - xa);
    end
    if (!mode_word[fscl_pkg::LIN_EN_BIT]) begin
      ylin = 64'(lin_in);
    end
    if (mode_word[fscl_pkg::OUT_INV_BIT]) begin
      ylin = -ylin;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_valid <= 1'b0;
      o_result <= '0;
    end else begin
      o_valid <= s3_valid_r;
      if (s3_valid_r) begin
        o_result.comp <= s3_y2_r;
        o_result.lin <= sat13(ylin);
      end
    end
  end

endmodule

`default_nettype wire

/* File: testbench/fscl_checker_assertions.sv */
// port checker of the field compensation and linearizer
`timescale 1ns/1ps
`default_nettype none
module fscl_checker (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_addr,
  input wire logic [23:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [23:0] o_rd_data,
  input wire logic i_valid,
  input wire fscl_pkg::sample_t i_sample,
  input wire logic o_valid,
  input wire fscl_pkg::result_t o_result
);
  logic [3:0] mode_r;
  logic signed [12:0] lin;
  logic signed [12:0] comp;
  assign lin = o_result.lin;
  assign comp = o_result.comp;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // copy of the table mode bits, enable in bit 0
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= 4'h0;
    end else if (i_wr && i_addr == fscl_pkg::ADDR_LIN_LAST) begin
      mode_r <= i_wr_data[15:12];
    end
  end
  valid_latency_a: assert property (i_valid |-> ##4 o_valid)
    else $error("result strobe late");
  valid_cause_a: assert property (o_valid |-> $past(i_valid, 4))
    else $error("result strobe without sample");
  result_hold_a: assert property (!o_valid |-> $stable(o_result))
    else $error("result moved without strobe");
  reg_readback_a: assert property (i_wr && i_addr inside {[5'h03:5'h07]}
    ##1 i_rd && i_addr == $past(i_addr) |=> o_rd_data == $past(i_wr_data, 2))
    else $error("register read back differs");
  unmapped_read_a: assert property (i_rd && i_addr == 5'h1F
    |=> o_rd_data == 24'h000000)
    else $error("unmapped read not zero");
  bypass_equal_a: assert property (o_valid && !mode_r[0]
    && mode_r[3] == mode_r[2]
    |-> lin == ((mode_r[3] && comp == 13'sh1000) ? 13'sh1001 : comp))
    else $error("disabled table changed value");
  bypass_invert_a: assert property (o_valid && !mode_r[0]
    && mode_r[3] != mode_r[2]
    |-> lin == ((comp == 13'sh1000) ? 13'sh0FFF : -comp))
    else $error("disabled table not inverted");
  bin_step_a: assert property (o_valid && mode_r[1:0] == 2'b11
    |-> lin[7:0] == 8'h00)
    else $error("bin output off grid");
  lin_limit_a: assert property (o_valid && mode_r[1:0] == 2'b01
    |-> lin >= -2304 && lin <= 2304)
    else $error("interpolated output past limit");
endmodule
bind field_signal_compensation_linearizer fscl_checker chk (.i_mclk, .i_rst_n,
  .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_valid, .i_sample,
  .o_valid, .o_result);
`default_nettype wire

/* File: testbench/field_source.sv */
// digitised field front end, one sample per request
`timescale 1ns/1ps
`default_nettype none
module field_source (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic signed [15:0] i_field,
  input wire logic signed [8:0] i_temp,
  output logic o_valid,
  output fscl_pkg::sample_t o_sample
);
  initial begin
    o_valid = 1'b0;
    o_sample = '0;
  end
  // outside a sample the bus inverts its previous word on every cycle, so it toggles
  always @(posedge i_mclk) begin
    o_valid <= i_go;
    o_sample <= i_go ? {i_field, i_temp} : ~o_sample;
  end
endmodule
`default_nettype wire

/* File: testbench/field_signal_compensation_linearizer_tb.sv */
// self-checking bench of the compensation and linearizer datapath
`timescale 1ns/1ps
`default_nettype none
module field_signal_compensation_linearizer_tb;
  logic i_mclk, i_rst_n, i_wr, i_rd, go, s_valid, o_valid;
  logic [4:0] i_addr;
  logic [23:0] i_wr_data, o_rd_data;
  logic signed [15:0] fld;
  logic signed [8:0] tmp;
  fscl_pkg::sample_t smp;
  fscl_pkg::result_t o_result;
  int errors, num_checks, cyc, pts[17];
  logic [31:0] seed;
  logic [12:0] exp_q[$];
  logic [23:0] cfg[32] = '{default: 24'h000000};
  logic [23:0] msk[5] = '{24'h00F7FF, 24'h7FF7FF, 24'h3FF3FF, 24'h00FFFF,
    24'hFFFFFF};
  field_source src (.i_mclk, .i_go(go), .i_field(fld), .i_temp(tmp),
    .o_valid(s_valid), .o_sample(smp));
  field_signal_compensation_linearizer uut (.i_mclk, .i_rst_n, .i_addr,
    .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_valid(s_valid),
    .i_sample(smp), .o_valid, .o_result);
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic longint sat(longint v, int w);
    longint m;
    m = (longint'(1) <<< (w - 1)) - 1;
    return v > m ? m : (v < -m - 1 ? -m - 1 : v);
  endfunction
  function automatic longint sx(logic [23:0] r, int lsb, int w);
    return longint'($signed(r << (24 - lsb - w))) >>> (24 - w);
  endfunction
  function automatic longint exp_comp(longint f, longint t);
    longint d, c, y, k;
    d = t - 25;
    k = d >= 0 ? 0 : 12;
    c = (sx(cfg[5], k, 10) * d + sx(cfg[4], k, 11) * 1000) * d * 64 / 100000;
    y = f * (1024 + longint'(cfg[3][10:0])) * (65536 + c);
    y = sat((y <<< cfg[3][14:12]) >>> 27, 17);
    if (cfg[3][15]) y = -y;
    return sat(y + sx(cfg[6], 0, 16) + ((sx(cfg[7], k, 12) * d) >>> 6), 13);
  endfunction
  function automatic longint exp_lin(longint c);
    longint x, y, n, d;
    logic [3:0] m;
    m = cfg[18][15:12];
    x = m[3] ? sat(-c, 13) : c;
    if (!m[0]) return m[2] ? sat(-x, 13) : x;
    n = 0;
    for (int k = 0; k < 17; k++) n += (pts[k] <= x);
    if (m[1]) y = n == 0 ? -2304 : -2048 + 256 * (n - 1);
    else if (n == 0) begin
      d = pts[1] - pts[0];
      y = d == 0 ? -2304 : -2048 + 256 * (x - pts[0]) / d;
      if (y < -2304) y = -2304;
    end else if (n == 17) begin
      d = pts[16] - pts[15];
      y = d == 0 ? 2304 : 2048 + 256 * (x - pts[16]) / d;
      if (y > 2304) y = 2304;
    end else begin
      y = -2048 + 256 * (n - 1) + 256 * (x - pts[n-1]) / (pts[n] - pts[n-1]);
    end
    return m[2] ? sat(-y, 13) : y;
  endfunction
  task automatic chk_reg(logic [23:0] got, logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_res(logic [12:0] got, logic [12:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t result %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [23:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    cfg[a] = d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [4:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk_reg(o_rd_data, cfg[a]);
  endtask
  task automatic send(logic signed [15:0] f, logic signed [8:0] t);
    go <= 1'b1;
    fld <= f;
    tmp <= t;
    exp_q.push_back(13'(exp_comp(f, t)));
    exp_q.push_back(13'(exp_lin(exp_comp(f, t))));
    cfg[1] = {11'h000, 13'(exp_comp(f, t))};
    @(posedge i_mclk);
    go <= 1'b0;
    #1;
  endtask
  task automatic drain();
    for (int i = 0; i < 9 && exp_q.size() > 0; i++) @(posedge i_mclk);
    #1;
  endtask
  task automatic complete_run();
    if (exp_q.size() != 0) begin
      errors++;
      $display("MISMATCH %0t %0d results missing", $time, exp_q.size());
    end
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (o_valid === 1'b1) begin
      chk_res(o_result.comp, exp_q.pop_front());
      chk_res(o_result.lin, exp_q.pop_front());
    end
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    seed = 32'hEF6B06CC;
    {i_rst_n, i_wr, i_rd, go, i_addr, i_wr_data, fld, tmp} = '0;
    cfg[3] = 24'h000400;
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    for (int a = 0; a < 32; a++) rd(5'(a));
    repeat (4) send(16'($signed(rnd()) >>> 20), 9'(int'(rnd() % 191) - 40));
    drain();
    repeat (5) begin
      for (int a = 3; a < 8; a++) begin
        wr(5'(a), 24'(rnd()) & msk[a-3]);
        rd(5'(a));
      end
      for (int j = 0; j < 6; j++) send(16'($signed(rnd()) >>> 21),
        j < 3 ? 9'(24 + j) : 9'(int'(rnd() % 191) - 40));
      drain();
      rd(5'h01);
    end
    for (int a = 3; a < 8; a++) wr(5'(a), a == 3 ? 24'h000400 : 24'h000000);
    pts[0] = -1900;
    for (int k = 1; k < 17; k++) pts[k] = pts[k-1] +
      ((k == 3 || k == 4 || rnd() % 5 == 0) ? 0 : int'(rnd() % 230));
    for (int k = 0; k < 8; k++) wr(5'(10 + k), {12'(pts[2*k+1]), 12'(pts[2*k])});
    for (int m = 0; m < 16; m++) begin
      wr(5'h12, {8'h00, 4'(m), 12'(pts[16])});
      send(16'(pts[2]), 9'h019);
      send(16'(pts[2] - 1), 9'h019);
      send(16'(pts[16] + 1), 9'h019);
      send(16'(pts[0] - 300), 9'h019);
      repeat (6) send(16'($signed(rnd()) >>> 19), 9'h019);
      drain();
    end
    complete_run();
  end
endmodule
`default_nettype wire
